/* File: include/pcw_pkg.sv */
// constants for the pwm cycle length configuration register
// assumes an sfr bus with page select driven by the cpu core
// Notes on behaviour
// - register answers at sfr address 0xd9 only while sfr page 0x0f is selected
// - bank select 0 steers compare accesses to compare values, 1 to auto-reload
// - in 9, 10 and 11-bit pwm the auto-reload value is the reload
// - other modes ignore auto-reload registers, though still readable and writable
// - irq enable bit 6 with flag set raises the shared array interrupt
// - flag sets on main counter overflow at bit 8, 9, 10 or 11 per length
// - flag bit 5 set by hardware or software, cleared only by software zero
// - bits 4 to 2 read zero, writes ignored
// - length code 00 is 8 bits, 10 is 10 bits, 11 is 11 bits
// - selected length applies to all non-16-bit pwm channels together
// - 16-bit pwm channels ignore the length field and use full counter
// - wide select 1 picks 16-bit pwm, 0 picks shared 8 to 11-bit length
package pcw_pkg;
    localparam logic [7:0] PCW_ADDR        = 8'hd9;
    localparam logic [7:0] PCW_PAGE        = 8'h0f;
    localparam logic [7:0] PCW_RESET       = 8'h00;
    localparam int         PCW_BANK_BIT    = 7;
    localparam int         PCW_IRQEN_BIT   = 6;
    localparam int         PCW_FLAG_BIT    = 5;
    localparam int         PCW_LEN_LSB     = 0;
    localparam logic [7:0] PCW_WMASK       = 8'he3;
    localparam logic [1:0] PCW_LEN_8       = 2'h0;
    localparam logic [1:0] PCW_LEN_9       = 2'h1;
    localparam logic [1:0] PCW_LEN_10      = 2'h2;
    localparam logic [1:0] PCW_LEN_11      = 2'h3;
endpackage

/* File: hdl/pcw_config.sv */
// pwm cycle length configuration register of the counter array
// assumes sfr bus strobes are one-cycle pulses synchronous to CLK_I
`timescale 1ns/1ns
module pcw_config #(
    parameter int CHANNELS = 6
) (
    input  wire logic                CLK_I,
    input  wire logic                RST_N_I,
    input  wire logic [7:0]          SFR_ADDR_I,
    input  wire logic [7:0]          SFR_PAGE_I,
    input  wire logic                SFR_WR_I,
    input  wire logic                SFR_RD_I,
    input  wire logic [7:0]          SFR_WDATA_I,
    output logic      [7:0]          SFR_RDATA_O,
    output logic                     SFR_HIT_O,
    input  wire logic [15:0]         MAIN_COUNTER_I,
    input  wire logic                COUNTER_TICK_I,
    input  wire logic [CHANNELS-1:0] WIDE_PWM_SELECT_I,
    input  wire logic [CHANNELS-1:0] PWM_MODE_I,
    output logic                     RELOAD_BANK_SELECT_O,
    output logic [CHANNELS-1:0]      USE_RELOAD_O,
    output logic [CHANNELS-1:0][15:0] CYCLE_MASK_O,
    output logic                     CYCLE_WRAP_FLAG_O,
    output logic                     IRQ_REQ_O
);
    import pcw_pkg::*;

    // ----------------------------------------------------------------
    // register decode
    // ----------------------------------------------------------------
    logic [7:0] cfg_r;
    logic [7:0] cfg_nxt;
    wire        sel      = (SFR_ADDR_I == PCW_ADDR) && (SFR_PAGE_I == PCW_PAGE);
    wire        wr_hit   = sel && SFR_WR_I;
    wire [1:0]  len_sel  = cfg_r[PCW_LEN_LSB +: 2];
    wire        bank_sel = cfg_r[PCW_BANK_BIT];
    wire        irq_en   = cfg_r[PCW_IRQEN_BIT];
    wire        flag     = cfg_r[PCW_FLAG_BIT];

    // top counter bit of the active cycle length
    function automatic logic [3:0] len_top(input logic [1:0] code);
        case (code)
            PCW_LEN_8:  len_top = 4'h7;
            PCW_LEN_9:  len_top = 4'h8;
            PCW_LEN_10: len_top = 4'h9;
            PCW_LEN_11: len_top = 4'ha;
            default:    len_top = 4'h7;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // cycle wrap detect
    // ----------------------------------------------------------------
    // a wrap is the counter bits below the cycle length all ones as the counter advances
    wire [3:0]  top       = len_top(len_sel);
    wire [15:0] len_mask  = 16'hffff >> (4'hf - top);
    wire        cycle_end = COUNTER_TICK_I && ((MAIN_COUNTER_I & len_mask) == len_mask);

    // ----------------------------------------------------------------
    // register update: hardware set wins over a software clear
    // ----------------------------------------------------------------
    always_comb begin
        cfg_nxt = cfg_r;
        if (wr_hit) begin
            cfg_nxt = SFR_WDATA_I & PCW_WMASK;
        end
        if (cycle_end) begin
            cfg_nxt[PCW_FLAG_BIT] = 1'b1;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            cfg_r <= PCW_RESET;
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign SFR_HIT_O            = sel && (SFR_RD_I || SFR_WR_I);
    assign SFR_RDATA_O          = cfg_r & PCW_WMASK;
    assign RELOAD_BANK_SELECT_O = bank_sel;
    assign CYCLE_WRAP_FLAG_O    = flag;
    assign IRQ_REQ_O            = flag && irq_en;

    // reload only matters for 9 to 11-bit pwm on narrow channels
    wire narrow_long = (len_sel != PCW_LEN_8);
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_ch
            assign USE_RELOAD_O[g] = PWM_MODE_I[g] && !WIDE_PWM_SELECT_I[g] && narrow_long;
            assign CYCLE_MASK_O[g] = WIDE_PWM_SELECT_I[g] ? 16'hffff : len_mask;
        end
    endgenerate

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    // named steps for the properties below; only s_take_write is shared, by two
    sequence s_wrap;
        cycle_end;
    endsequence

    sequence s_take_write;
        wr_hit;
    endsequence

    sequence s_foreign_write;
        SFR_WR_I && !sel;
    endsequence

    sequence s_set_irq_by_write;
        wr_hit && SFR_WDATA_I[PCW_IRQEN_BIT] && SFR_WDATA_I[PCW_FLAG_BIT];
    endsequence

    // a wrap while the interrupt is enabled and no write can disturb it
    sequence s_armed_wrap;
        irq_en && !wr_hit && cycle_end;
    endsequence

    // two sampled edges in reset so the asynchronous clear has landed before the check
    sequence s_in_reset;
        !RST_N_I ##1 !RST_N_I;
    endsequence

    // ----------------------------------------------------------------
    // checks: decode and fields
    // ----------------------------------------------------------------
    AST_DECODE: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        s_foreign_write |=> (cfg_r[7:6] == $past(cfg_r[7:6])) && (cfg_r[1:0] == $past(cfg_r[1:0]))
            && (flag || !$past(flag)))
        else $error("write outside this register changed it");
    AST_HIT: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        SFR_HIT_O |-> (SFR_ADDR_I == PCW_ADDR) && (SFR_PAGE_I == PCW_PAGE))
        else $error("register answered outside its address");
    AST_BANK: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        wr_hit |=> RELOAD_BANK_SELECT_O == $past(SFR_WDATA_I[PCW_BANK_BIT]))
        else $error("bank select not written");
    AST_WRITE_TAKEN: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        s_take_write |=> (irq_en == $past(SFR_WDATA_I[PCW_IRQEN_BIT]))
            && (len_sel == $past(SFR_WDATA_I[PCW_LEN_LSB +: 2])))
        else $error("enable or length field not written");
    AST_UNUSED_ZERO: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        SFR_RDATA_O[4:2] == 3'h0)
        else $error("unused bits not zero");
    AST_UNUSED_IGNORED: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        s_take_write |=> cfg_r[4:2] == 3'h0)
        else $error("unused bits stored a write");

    // ----------------------------------------------------------------
    // checks: flag and interrupt
    // ----------------------------------------------------------------
    AST_WRAP_SETS: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        s_wrap |=> CYCLE_WRAP_FLAG_O)
        else $error("wrap did not set flag");
    AST_WRAP_NEEDS_EVENT: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (!cycle_end && !wr_hit && !flag) |=> !flag)
        else $error("flag set without wrap or write");
    AST_NO_HW_CLEAR: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (flag && !wr_hit) |=> flag)
        else $error("flag cleared without write");
    AST_SW_CLEAR: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (wr_hit && !SFR_WDATA_I[PCW_FLAG_BIT] && !cycle_end) |=> !flag)
        else $error("software clear ignored");
    AST_SW_SET: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (wr_hit && SFR_WDATA_I[PCW_FLAG_BIT]) |=> flag)
        else $error("software set ignored");
    AST_IRQ: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        s_set_irq_by_write |=> IRQ_REQ_O)
        else $error("irq missing after enable and flag written");
    AST_IRQ_ON_WRAP: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        s_armed_wrap |=> IRQ_REQ_O)
        else $error("irq missing after enabled wrap");
    AST_IRQ_MASKED: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        !irq_en |-> !IRQ_REQ_O)
        else $error("irq raised while disabled");

    // ----------------------------------------------------------------
    // checks: cycle length
    // ----------------------------------------------------------------
    AST_LEN8: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (len_sel == PCW_LEN_8 && !WIDE_PWM_SELECT_I[0]) |-> CYCLE_MASK_O[0] == 16'h00ff)
        else $error("8-bit mask wrong");
    AST_LEN9: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (len_sel == PCW_LEN_9 && !WIDE_PWM_SELECT_I[0]) |-> CYCLE_MASK_O[0] == 16'h01ff)
        else $error("9-bit mask wrong");
    AST_LEN10: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (len_sel == PCW_LEN_10 && !WIDE_PWM_SELECT_I[0]) |-> CYCLE_MASK_O[0] == 16'h03ff)
        else $error("10-bit mask wrong");
    AST_LEN11: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (len_sel == PCW_LEN_11 && !WIDE_PWM_SELECT_I[0]) |-> CYCLE_MASK_O[0] == 16'h07ff)
        else $error("11-bit mask wrong");
    AST_SHARED_LEN: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (!WIDE_PWM_SELECT_I[0] && !WIDE_PWM_SELECT_I[CHANNELS-1]) |-> CYCLE_MASK_O[0] == CYCLE_MASK_O[CHANNELS-1])
        else $error("narrow channels disagree on length");
    AST_NARROW_TOP: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        !WIDE_PWM_SELECT_I[0] |-> CYCLE_MASK_O[0][15:11] == 5'h00)
        else $error("narrow channel longer than 11 bits");
    AST_WIDE: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        WIDE_PWM_SELECT_I[0] |-> (CYCLE_MASK_O[0] == 16'hffff && !USE_RELOAD_O[0]))
        else $error("wide channel not full length");
    AST_WIDE_LAST: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        WIDE_PWM_SELECT_I[CHANNELS-1] |-> (CYCLE_MASK_O[CHANNELS-1] == 16'hffff && !USE_RELOAD_O[CHANNELS-1]))
        else $error("last wide channel not full length");
    AST_RELOAD_USE: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (PWM_MODE_I[0] && !WIDE_PWM_SELECT_I[0] && len_sel != PCW_LEN_8) |-> USE_RELOAD_O[0])
        else $error("reload not used in 9 to 11-bit pwm");
    AST_RELOAD_IDLE: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (!PWM_MODE_I[0] || len_sel == PCW_LEN_8) |-> !USE_RELOAD_O[0])
        else $error("reload used outside 9 to 11-bit pwm");

    // ----------------------------------------------------------------
    // checks: reset
    // ----------------------------------------------------------------
    AST_RESET_CLEAR: assert property (@(posedge CLK_I)
        s_in_reset |-> (cfg_r == PCW_RESET) && (SFR_RDATA_O == 8'h00) && !IRQ_REQ_O && !RELOAD_BANK_SELECT_O)
        else $error("register not cleared by reset");
endmodule // pcw_config

/* File: sim/pcw_config_test.sv */
// self-checking bench for the pwm cycle length configuration register
// assumes pcw_pkg is compiled first; the bench drives every port itself
`timescale 1ns/1ns
module pcw_config_test;
    import pcw_pkg::*;
    logic             clk_i = 1'b0, rst_n_i = 1'b0, wr = 1'b0, rd = 1'b0, tick = 1'b0;
    logic [7:0]       addr = 8'h00, page = 8'h00, wdata = 8'h00, rdata;
    logic [15:0]      cnt = 16'h0000;
    logic [5:0]       wide = 6'h02, pwm = 6'h0b, use_rl;
    logic [5:0][15:0] mask;
    logic             hit, bank, flag, irq;
    int               fails = 0, num_checks = 0, cycles = 0;
    pcw_config #(.CHANNELS(6)) pcw_config_i (.CLK_I(clk_i), .RST_N_I(rst_n_i), .SFR_ADDR_I(addr),
        .SFR_PAGE_I(page), .SFR_WR_I(wr), .SFR_RD_I(rd), .SFR_WDATA_I(wdata), .SFR_RDATA_O(rdata),
        .SFR_HIT_O(hit), .MAIN_COUNTER_I(cnt), .COUNTER_TICK_I(tick), .WIDE_PWM_SELECT_I(wide),
        .PWM_MODE_I(pwm), .RELOAD_BANK_SELECT_O(bank), .USE_RELOAD_O(use_rl), .CYCLE_MASK_O(mask),
        .CYCLE_WRAP_FLAG_O(flag), .IRQ_REQ_O(irq));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    // whole run needs under two hundred cycles; the ceiling only catches a hang
    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 1000) begin
            fails++;
            close_out();
        end
    end
    // ----------------------------------------------------------------
    // bus tasks and comparison
    // ----------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // strobes drop one cycle before the next task can raise them again
    task automatic sfr_wr(input logic [7:0] a, p, d, input logic h);
        @(posedge clk_i) #1 {addr, page, wdata, wr} = {a, p, d, 1'b1};
        #1 chk(16'(hit), 16'(h));
        @(posedge clk_i) #1 wr = 1'b0;
    endtask
    task automatic sfr_rd(input logic [7:0] e);
        @(posedge clk_i) #1 {addr, page, rd} = {PCW_ADDR, PCW_PAGE, 1'b1};
        #1 chk(16'(hit), 16'h0001);
        chk(16'(rdata), 16'(e));
        @(posedge clk_i) #1 rd = 1'b0;
    endtask
    task automatic pulse(input logic [15:0] c);
        @(posedge clk_i) #1 {cnt, tick} = {c, 1'b1};
        @(posedge clk_i) #1 tick = 1'b0;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_fields();
        sfr_rd(8'h00);
        sfr_wr(PCW_ADDR, 8'h00, 8'hff, 1'b0);
        sfr_wr(8'hd8, PCW_PAGE, 8'hff, 1'b0);
        sfr_rd(8'h00);
        sfr_wr(PCW_ADDR, PCW_PAGE, 8'hff, 1'b1);
        sfr_rd(8'he3);
        chk(16'({bank, irq}), 16'h0003);
        sfr_wr(PCW_ADDR, PCW_PAGE, 8'h20, 1'b1);
        chk(16'({bank, flag, irq}), 16'h0002);
        sfr_wr(PCW_ADDR, PCW_PAGE, 8'h00, 1'b1);
        chk(16'(flag), 16'h0000);
    endtask
    task automatic t_lengths();
        logic [15:0] m;
        for (int i = 0; i < 4; i++) begin
            m = (16'h0100 << i) - 16'h0001;
            sfr_wr(PCW_ADDR, PCW_PAGE, 8'(i), 1'b1);
            chk(mask[0], m);
            chk(mask[3], m);
            chk(mask[1], 16'hffff);
            chk(16'(use_rl), 16'((i != 0) ? 6'h09 : 6'h00));
            pulse(m - 16'h0001);
            chk(16'(flag), 16'h0000);
            pulse(m >> 1);
            chk(16'(flag), 16'h0000);
            pulse(m);
            chk(16'(flag), 16'h0001);
            pulse(16'h0000);
            chk(16'(flag), 16'h0001);
        end
    endtask
    task automatic t_irq();
        sfr_wr(PCW_ADDR, PCW_PAGE, 8'h40, 1'b1);
        chk(16'({flag, irq}), 16'h0000);
        pulse(16'h00ff);
        chk(16'({flag, irq}), 16'h0003);
        // a clear that meets a wrap in the same cycle loses to the wrap
        @(posedge clk_i) #1 {addr, page, wdata, wr, cnt, tick} = {PCW_ADDR, PCW_PAGE, 8'h40, 1'b1, 16'h00ff, 1'b1};
        @(posedge clk_i) #1 {wr, tick} = 2'b00;
        chk(16'({flag, irq}), 16'h0003);
        sfr_wr(PCW_ADDR, PCW_PAGE, 8'h00, 1'b1);
        chk(16'(irq), 16'h0000);
    endtask
    task automatic t_wide();
        sfr_wr(PCW_ADDR, PCW_PAGE, 8'h02, 1'b1);
        @(posedge clk_i) #1 wide = 6'h23;
        #1 chk(mask[0], 16'hffff);
        chk(mask[5], 16'hffff);
        chk(mask[3], 16'h03ff);
        chk(16'(use_rl), 16'h0008);
        @(posedge clk_i) #1 wide = 6'h02;
    endtask
    task automatic t_reset();
        sfr_wr(PCW_ADDR, PCW_PAGE, 8'he3, 1'b1);
        chk(16'({bank, flag, irq}), 16'h0007);
        @(posedge clk_i) #1 rst_n_i = 1'b0;
        repeat (3) @(posedge clk_i);
        #1 chk(16'({bank, flag, irq}), 16'h0000);
        chk(16'(rdata), 16'h0000);
        chk(mask[0], 16'h00ff);
        rst_n_i = 1'b1;
        sfr_rd(8'h00);
    endtask
    task automatic close_out();
        if (fails == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        #1 rst_n_i = 1'b1;
        t_fields();
        t_lengths();
        t_irq();
        t_wide();
        t_reset();
        close_out();
    end
endmodule // pcw_config_test
